/* design/io_pin_function_sync.sv */
`timescale 1ns/100ps
`default_nettype none
`include "io_pin_params.svh"
module io_pin_function_sync (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [10:0] pin_in_i,
    output logic      [10:0] pin_out_o,
    output logic      [10:0] pin_oe_o,
    input  wire logic [1:0]  mode_i,
    input  wire logic [7:0]  level_detect_en_i,
    input  wire logic        sample_req_i,
    output logic      [10:0] sample_data_o,
    output logic      [7:0]  level_flag_o,
    output logic             sample_valid_o,
    input  wire logic [3:0]  timer_sel_i,
    output logic      [15:0] edge_count_o,
    input  wire logic        xfer_start_i,
    input  wire logic        xfer_write_i,
    input  wire logic [7:0]  xfer_len_i,
    input  wire logic [7:0]  xfer_data_i,
    input  wire logic        xfer_addr_phase_i,
    output logic             app_stall_o,
    output logic             xfer_done_o,
    output logic      [7:0]  xfer_rdata_o,
    input  wire logic        net_tx_i,
    output logic             net_tx_o
);
    // ****************************************
    // system tick and synchroniser
    // ****************************************
    logic              tick_q, tick_d;
    pin_sync_if        psif();

    always_comb begin
        tick_d = ~tick_q;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) tick_q <= 1'b0;
        else         tick_q <= tick_d;
    end

    assign psif.raw      = pin_in_i;
    assign psif.sys_tick = tick_q;

    pin_sync u_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .sif    (psif)
    );

    function automatic logic is_fall(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction : is_fall

    // ****************************************
    // previous synced level for edge detection
    // ****************************************
    logic [10:0] syn;
    logic [10:0] prev_q, prev_d;

    assign syn = psif.synced;

    always_comb begin
        prev_d = prev_q;
        if (tick_q) begin
            prev_d = syn;
        end
    end

    always_ff @(posedge clk_i) begin
        // same idle level as the synchroniser, so no false edge after reset
        if (!rstn_i) begin
            prev_q <= `SYNC_RESET;
        end else begin
            prev_q <= prev_d;
        end
    end

    // ****************************************
    // software sample of plain inputs
    // ****************************************
    logic [10:0] samp_q, samp_d;
    logic        sv_q, sv_d;

    always_comb begin
        samp_d = samp_q;
        sv_d   = 1'b0;
        if (sample_req_i) begin
            samp_d = syn;
            sv_d   = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            samp_q <= `SYNC_RESET;
            sv_q   <= 1'b0;
        end else begin
            samp_q <= samp_d;
            sv_q   <= sv_d;
        end
    end

    // ****************************************
    // sticky falling-edge latches, pins 0 to 7
    // ****************************************
    wire logic [7:0] lvl_w;

    for (genvar g = 0; g < 8; g++) begin : g_level
        logic flag_q, flag_d;

        always_comb begin
            flag_d = flag_q;
            if (sample_req_i) begin
                flag_d = 1'b0;
            end
            // a fall in the clearing cycle wins over the clear
            if (tick_q && level_detect_en_i[g] && is_fall(prev_q[g], syn[g])) begin
                flag_d = 1'b1;
            end
        end

        always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
                flag_q <= 1'b0;
            end else begin
                flag_q <= flag_d;
            end
        end

        assign lvl_w[g] = flag_q;
    end

    // ****************************************
    // timer input: falls on pins 4 to 7
    // ****************************************
    logic [15:0] cnt_q, cnt_d;
    logic        tmr_fall;

    always_comb begin
        tmr_fall = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (timer_sel_i[i] && is_fall(prev_q[i + 4], syn[i + 4])) begin
                tmr_fall = 1'b1;
            end
        end
        cnt_d = cnt_q;
        if (tick_q && tmr_fall) begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ****************************************
    // firmware transfer control
    // ****************************************
    io_pin_pkg::xfer_state_e st_q, st_d;
    logic [7:0]              left_q, left_d;
    logic                    done_q, done_d, stall_q, stall_d;
    logic                    step;

    // one unit moves per system tick while busy
    assign step = (st_q == io_pin_pkg::XFER_BUSY) && tick_q;

    always_comb begin
        st_d    = st_q;
        left_d  = left_q;
        done_d  = 1'b0;
        stall_d = stall_q;
        case (st_q)
            io_pin_pkg::XFER_IDLE: begin
                if (xfer_start_i && xfer_len_i != 8'h00) begin
                    st_d    = io_pin_pkg::XFER_BUSY;
                    left_d  = xfer_len_i;
                    stall_d = 1'b1;
                end
            end
            io_pin_pkg::XFER_BUSY: begin
                if (step) begin
                    left_d = left_q - 8'h01;
                    if (left_q == 8'h01) begin
                        st_d = io_pin_pkg::XFER_DONE;
                    end
                end
            end
            io_pin_pkg::XFER_DONE: begin
                st_d    = io_pin_pkg::XFER_IDLE;
                done_d  = 1'b1;
                stall_d = 1'b0;
            end
            default: begin
                st_d = io_pin_pkg::XFER_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_q    <= io_pin_pkg::XFER_IDLE;
            left_q  <= 8'h00;
            done_q  <= 1'b0;
            stall_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            left_q  <= left_d;
            done_q  <= done_d;
            stall_q <= stall_d;
        end
    end

    // ****************************************
    // pin drive and read data of the objects
    // ****************************************
    logic [7:0]  rd_q, rd_d;
    logic [10:0] out_q, out_d, oe_q, oe_d;

    always_comb begin
        rd_d  = rd_q;
        out_d = out_q;
        oe_d  = oe_q;
        if (st_q != io_pin_pkg::XFER_BUSY) begin
            oe_d = 11'h000;
        end else if (step) begin
            case (io_pin_pkg::pin_mode_e'(mode_i))
                io_pin_pkg::MODE_SERIAL: begin
                    out_d[`SERIAL_CLK_PIN]   = ~out_q[`SERIAL_CLK_PIN];
                    out_d[`SERIAL_DATA0_PIN] = xfer_data_i[0];
                    oe_d = 11'h300 | {xfer_write_i, 10'h000};
                    rd_d = {rd_q[6:0], syn[`SERIAL_DATA1_PIN]};
                end
                io_pin_pkg::MODE_PARALLEL: begin
                    out_d = {3'b001, xfer_data_i};
                    oe_d  = {3'b111, {8{xfer_write_i}}};
                    rd_d  = syn[7:0];
                end
                io_pin_pkg::MODE_MUXBUS: begin
                    out_d[7:0]               = xfer_data_i;
                    out_d[`ADDR_STROBE_PIN]  = xfer_addr_phase_i;
                    out_d[`WRITE_STROBE_PIN] = xfer_write_i & ~xfer_addr_phase_i;
                    out_d[`READ_STROBE_PIN]  = ~xfer_write_i & ~xfer_addr_phase_i;
                    oe_d = {3'b111, {8{xfer_write_i | xfer_addr_phase_i}}};
                    rd_d = syn[7:0];
                end
                default: begin
                    oe_d = 11'h000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_q  <= 8'h00;
            out_q <= 11'h000;
            oe_q  <= 11'h000;
        end else begin
            rd_q  <= rd_d;
            out_q <= out_d;
            oe_q  <= oe_d;
        end
    end

    // ****************************************
    // network path, untouched by a stall
    // ****************************************
    logic net_q, net_d;

    always_comb begin
        net_d = net_tx_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            net_q <= 1'b0;
        end else begin
            net_q <= net_d;
        end
    end

    assign pin_out_o      = out_q;
    assign pin_oe_o       = oe_q;
    assign sample_data_o  = samp_q;
    assign sample_valid_o = sv_q;
    assign level_flag_o   = lvl_w;
    assign edge_count_o   = cnt_q;
    assign app_stall_o    = stall_q;
    assign xfer_done_o    = done_q;
    assign xfer_rdata_o   = rd_q;
    assign net_tx_o       = net_q;
endmodule : io_pin_function_sync
`default_nettype wire

/* design/io_pin_params.svh */
`ifndef IO_PIN_PARAMS_SVH
`define IO_PIN_PARAMS_SVH

`define PIN_COUNT           11
`define SYS_CLK_DIV         2
`define INPUT_CLK_MHZ       125
`define MIN_HOLD_NS         220
`define LEVEL_CLK_NS        200
`define CLK_PERIOD_NS       8
`define MIN_HOLD_CYCLES     ((`MIN_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SERIAL_CLK_PIN      8
`define SERIAL_DATA0_PIN    9
`define SERIAL_DATA1_PIN    10
`define ADDR_STROBE_PIN     8
`define WRITE_STROBE_PIN    9
`define READ_STROBE_PIN     10
`define MAX_XFER_COUNT      8'hFF
`define SYNC_RESET          11'h000

`endif

/* design/io_pin_pkg.sv */
package io_pin_pkg;
    typedef enum logic [1:0] {
        MODE_DIRECT   = 2'b00,
        MODE_SERIAL   = 2'b01,
        MODE_PARALLEL = 2'b10,
        MODE_MUXBUS   = 2'b11
    } pin_mode_e;

    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_BUSY = 2'b01,
        XFER_DONE = 2'b10
    } xfer_state_e;

    typedef logic [10:0] pin_vec_t;
endpackage : io_pin_pkg

/* design/pin_sync_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if;
    logic [10:0] raw;
    logic [10:0] synced;
    logic        sys_tick;
    modport sync_side (input raw, input sys_tick, output synced);
    modport user_side (output raw, output sys_tick, input synced);
endinterface : pin_sync_if
`default_nettype wire

/* design/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
`include "io_pin_params.svh"
// ****************************************
// three-stage synchroniser on system tick
// ****************************************
module pin_sync (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    pin_sync_if.sync_side   sif
);
    logic [10:0] s1_q, s2_q, s3_q, out_q;
    logic [10:0] s1_d, s2_d, s3_d, out_d;

    always_comb begin
        s1_d  = s1_q;
        s2_d  = s2_q;
        s3_d  = s3_q;
        out_d = out_q;
        if (sif.sys_tick) begin
            s1_d = sif.raw;
            s2_d = s1_q;
            s3_d = s2_q;
            // level accepted when stage two and three agree
            for (int i = 0; i < 11; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    out_d[i] = s3_q[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s1_q  <= `SYNC_RESET;
            s2_q  <= `SYNC_RESET;
            s3_q  <= `SYNC_RESET;
            out_q <= `SYNC_RESET;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            out_q <= out_d;
        end
    end

    assign sif.synced = out_q;
endmodule : pin_sync
`default_nettype wire

/* tb/io_pin_function_sync_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module io_pin_monitor (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        sample_req_i,
    input wire logic        sample_valid_o,
    input wire logic        xfer_start_i,
    input wire logic [7:0]  xfer_len_i,
    input wire logic [1:0]  mode_i,
    input wire logic        app_stall_o,
    input wire logic        xfer_done_o,
    input wire logic        net_tx_i,
    input wire logic        net_tx_o,
    input wire logic [10:0] pin_out_o,
    input wire logic [10:0] pin_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    AST_SAMPLE_ANSWER: assert property (sample_req_i |=> sample_valid_o)
        else $error("sample unanswered");
    AST_SAMPLE_CAUSE: assert property (sample_valid_o |-> $past(sample_req_i))
        else $error("unrequested sample");
    AST_STALL_START: assert property (
        xfer_start_i && xfer_len_i != 8'h00 && mode_i != 2'h0 && !app_stall_o |=> app_stall_o)
        else $error("no stall");
    AST_DONE_CAUSE: assert property (xfer_done_o |-> $past(app_stall_o))
        else $error("done without transfer");
    AST_DONE_PULSE: assert property (xfer_done_o |=> !xfer_done_o && !app_stall_o)
        else $error("done not single");
    AST_NET_PASS: assert property ($past(rstn_i) |-> net_tx_o == $past(net_tx_i))
        else $error("net path disturbed");
    AST_SERIAL_PINS: assert property (
        app_stall_o && mode_i == 2'h1 && $stable(mode_i) |-> pin_oe_o[7:0] == 8'h00)
        else $error("serial drives data pins");
    AST_STROBE_EXCL: assert property (
        mode_i == 2'h3 |-> !(pin_oe_o[9] && pin_oe_o[10] && pin_out_o[9] && pin_out_o[10]))
        else $error("both strobes");
endmodule : io_pin_monitor
bind io_pin_function_sync io_pin_monitor mon_u (.clk_i, .rstn_i, .sample_req_i,
    .sample_valid_o, .xfer_start_i, .xfer_len_i, .mode_i, .app_stall_o, .xfer_done_o,
    .net_tx_i, .net_tx_o, .pin_out_o, .pin_oe_o);
`default_nettype wire

/* tb/pin_drive_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_drive_model #(
    parameter int HOLD = 28
) (
    input  wire logic [10:0] want_i,
    input  wire logic        clk_i,
    output logic      [10:0] pin_o
);
    int cnt [11];
    initial pin_o = 11'h000;
    // each level stands at least the hold time
    always @(posedge clk_i) begin
        for (int i = 0; i < 11; i++) begin
            if (pin_o[i] !== want_i[i] && cnt[i] >= HOLD) begin
                pin_o[i] <= want_i[i];
                cnt[i] <= 0;
            end else if (cnt[i] < HOLD) begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule : pin_drive_model
`default_nettype wire

/* tb/io_pin_function_sync_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "io_pin_params.svh"
module io_pin_function_sync_tb_top;
    logic        clk_i = 1'b0, rstn_i = 1'b0, sample_req_i = 1'b0, xfer_start_i = 1'b0;
    logic        xfer_write_i = 1'b0, xfer_addr_phase_i = 1'b0, net_tx_i = 1'b0, nprev;
    logic        sample_valid_o, app_stall_o, xfer_done_o, net_tx_o;
    logic [10:0] want = 11'h000, old, mdl_pin, pin_in_i, pin_out_o, pin_oe_o, sample_data_o;
    logic [7:0]  level_detect_en_i = 8'h00, xfer_len_i = 8'h00, xfer_data_i = 8'h00;
    logic [7:0]  level_flag_o, xfer_rdata_o;
    logic [1:0]  mode_i = 2'h0;
    logic [3:0]  timer_sel_i = 4'h0;
    logic [15:0] edge_count_o, exp_cnt = 16'h0000;
    int          num_errors = 0, checked = 0, cyc = 0;
    integer      seed = 32'hB0A553A6;
    always #4 clk_i = ~clk_i;
    assign pin_in_i = (pin_oe_o & pin_out_o) | (~pin_oe_o & mdl_pin);
    pin_drive_model #(.HOLD(`MIN_HOLD_CYCLES)) mdl_u (.clk_i, .want_i(want), .pin_o(mdl_pin));
    io_pin_function_sync dut_u (.*);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    function automatic logic [7:0] falls(input logic [10:0] a, input logic [10:0] b);
        return level_detect_en_i & a[7:0] & ~b[7:0];
    endfunction : falls
    task automatic sample(input logic [10:0] d, input logic [7:0] f);
        #1;
        chk("level_flag", 16'(f), 16'(level_flag_o));
        @(posedge clk_i);
        sample_req_i <= 1'b1;
        @(posedge clk_i);
        sample_req_i <= 1'b0;
        #1;
        chk("valid", 16'h0001, 16'(sample_valid_o));
        chk("data", 16'(d), 16'(sample_data_o));
        chk("flag_clear", 16'h0000, 16'(level_flag_o));
    endtask : sample
    task automatic xfer(input logic [1:0] m, input logic w);
        logic [2:0] msk;
        msk = (m == 2'h1) ? 3'h1 : 3'h7;
        mode_i <= m;
        xfer_write_i <= w;
        xfer_len_i <= 8'(3 + ($random(seed) & 3));
        xfer_data_i <= 8'($random(seed));
        xfer_addr_phase_i <= 1'($random(seed));
        repeat (10) @(posedge clk_i);
        xfer_start_i <= 1'b1;
        @(posedge clk_i);
        xfer_start_i <= 1'b0;
        #1;
        chk("stall", 16'h0001, 16'(app_stall_o));
        repeat (3) @(posedge clk_i);
        #1;
        chk("ctl_oe", 16'(msk), 16'(pin_oe_o[10:8] & msk));
        if (m == 2'h2) chk("ctl_out", 16'h0001, 16'(pin_out_o[10:8]));
        for (int k = 0; k < 40 && xfer_done_o !== 1'b1; k++) begin
            @(posedge clk_i);
            #1;
        end
        chk("done", 16'h0001, 16'(xfer_done_o));
        if (m == 2'h1 && !w) chk("rdata", 16'({3{want[10]}}), 16'(xfer_rdata_o[2:0]));
        if (m == 2'h2 && !w) chk("rdata", 16'(want[7:0]), 16'(xfer_rdata_o));
        @(posedge clk_i);
    endtask : xfer
    always @(posedge clk_i) begin
        net_tx_i <= 1'($random(seed));
        nprev <= net_tx_i;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report;
        end
    end
    always @(negedge clk_i) if (rstn_i && cyc > 7) chk("net", 16'(nprev), 16'(net_tx_o));
    initial begin
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        level_detect_en_i <= 8'($random(seed));
        timer_sel_i <= 4'h1;
        for (int i = 0; i < 10; i++) begin
            old = want;
            want <= (i == 0) ? 11'h7FF : (i == 1) ? 11'h000 : 11'($random(seed));
            repeat (60) @(posedge clk_i);
            sample(want, falls(old, want));
            exp_cnt = exp_cnt + 16'(old[4] & ~want[4]);
            chk("edge_count", exp_cnt, edge_count_o);
        end
        for (int m = 1; m < 4; m++) begin
            xfer(2'(m), 1'b1);
            xfer(2'(m), 1'b0);
        end
        final_report;
    end
endmodule : io_pin_function_sync_tb_top
`default_nettype wire
